// ===== verilog/lp_clock_pkg.sv
// Shared constants for the processor clock-stop link
package lp_clock_pkg;
  localparam int          ADDR_W          = 24;
  localparam int          DATA_W          = 16;
  localparam int          FC_W            = 3;
  localparam int          IPL_W           = 3;
  localparam int          CNT_W           = 3;
  localparam logic [23:0] LP_ADDRESS      = 24'hFFF000;
  localparam logic [2:0]  FC_SUPER_DATA   = 3'h5;
  localparam logic [2:0]  FC_SUPER_PROG   = 3'h6;
  localparam logic [2:0]  FC_USER_DATA    = 3'h1;
  localparam logic [2:0]  CYCLES_16BIT    = 3'h3;
  localparam logic [2:0]  CYCLES_8BIT     = 3'h4;
  localparam logic [1:0]  IMM_FETCH_16BIT = 2'h1;
  localparam logic [1:0]  IMM_FETCH_8BIT  = 2'h2;
  localparam logic [15:0] STATUS_RESET    = 16'h2700;
  localparam int          STATUS_SUPER    = 13;
  localparam int          STATUS_MASK_LO  = 8;
  localparam int          STATUS_MASK_HI  = 10;
  localparam logic [15:0] LP_WRITE_DATA   = 16'h0000;
endpackage

// ===== verilog/lp_clock_if.sv
// Bus and clock link between processor and clock-stop logic
`timescale 1ns/1ps
interface lp_clock_if;
  import lp_clock_pkg::*;
  logic [ADDR_W-1:0] cpu_address_lines;
  logic [DATA_W-1:0] cpu_data_lines;
  logic [FC_W-1:0]   cycle_function_code;
  logic              read_write;
  logic              addr_strobe;
  logic              bus_drive_en;
  logic              byte_mode;
  logic              bus_grant;
  logic              bus_request_in;
  logic [IPL_W-1:0]  interrupt_level_in;
  logic              cpu_clk_en;

  modport cpu (
    output cpu_address_lines, cpu_data_lines, cycle_function_code, read_write,
    output addr_strobe, bus_drive_en, byte_mode, bus_grant,
    input  bus_request_in, interrupt_level_in, cpu_clk_en
  );
  modport ctl (
    input  cpu_address_lines, cpu_data_lines, cycle_function_code, read_write,
    input  addr_strobe, bus_drive_en, byte_mode, bus_grant,
    output bus_request_in, interrupt_level_in, cpu_clk_en
  );
endinterface

// ===== verilog/bus_cycle_counter.sv
// Counts qualified bus cycles from a start strobe up to a target
`timescale 1ns/1ps
module bus_cycle_counter #(
  parameter int W = 3
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         clear,
  input  wire logic         start,
  input  wire logic         strobe,
  input  wire logic [W-1:0] target,
  output logic      [W-1:0] count,
  output logic              done
);
  logic [W-1:0] count_reg;
  logic         done_reg;
  logic         active_reg;
  logic [W-1:0] count_next;

  // Start counts as the first cycle; later strobes only while active
  assign count_next = start ? W'(1) : count_reg + W'(1);

  // Reset and clear both drop back to zero
  always_ff @(posedge core_clk)
  begin
    if (!nrst || clear)
    begin
      count_reg  <= '0;
      active_reg <= 1'b0;
      done_reg   <= 1'b0;
    end
    else if (start || (active_reg && strobe))
    begin
      count_reg  <= count_next;
      active_reg <= (count_next != target);
      done_reg   <= (count_next == target);
    end
  end

  assign count = count_reg;
  assign done  = done_reg;
endmodule // bus_cycle_counter

// ===== verilog/lp_clock_ctl.sv
// External clock-stop and restart logic watching the processor bus
//
// Overview of operation
// - Low power entered only from supervisor mode
// - Hit on address, write, supervisor data code
// - Trigger address any 24-bit location
// - Count cycles, gate clock after immediate fetch
// - Byte mode adds one immediate fetch cycle
// - Clock gating never makes runt pulses
// - Optional bus handover during status fetch
// - Stay stopped until expected interrupt level
// - Wake needs stable system clock first
// - Restart enables clock at next edge
// - Never restart before clock is stable
// - Negate bus request before resuming execution
// - Processor state held while clock stopped
// - Static byte or word data width
// - Arbitration by request and grant only
// - Trap routine writes byte to trigger address
// - Stop operand loads status word, mask
//
// Limitations: the processor clock enable is a registered level, and the
// clock cell must latch it while the clock is low so that no phase is cut.
// Interrupt lines and the stable flag are pins; both pass two flip-flops.
// A trigger write seen outside the running state is ignored, so a stray
// write during the count cannot start a second sequence.
`timescale 1ns/1ps
module lp_clock_ctl
  import lp_clock_pkg::*;
#(
  parameter logic [23:0] TRIGGER_ADDRESS = LP_ADDRESS
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  lp_clock_if.ctl               link,
  input  wire logic [IPL_W-1:0] irq_level,
  input  wire logic [IPL_W-1:0] wake_level,
  input  wire logic             clock_stable,
  input  wire logic             tristate_en,
  output logic                  cpu_stopped,
  output logic                  wake_done
);
  import lp_clock_pkg::*;

  typedef enum logic [2:0] {RUN, COUNTING, STOPPED, WAKING, RESUMING} ctl_state_t;

  // Clock held off, either waiting for the level or for a stable clock;
  // the status output reports both so software sees one stopped span
  function automatic logic is_parked(input ctl_state_t s);
    return (s == STOPPED) || (s == WAKING);
  endfunction

  ctl_state_t       state_reg, state_next;
  logic             clk_en_reg;
  logic             bus_req_reg;
  logic [IPL_W-1:0] ipl_reg;
  logic             stopped_reg;
  logic             wake_done_reg;
  logic             stable_meta_reg;
  logic             stable_sync_reg;
  logic [CNT_W-1:0] cycle_count;
  logic             count_done;
  logic [CNT_W-1:0] cycle_target;
  logic             lp_hit;
  logic             last_fetch;
  logic             level_seen;
  logic [IPL_W-1:0] ipl_meta_reg;
  logic             stop_go;
  logic             restart_go;
  logic             counter_clear;

  // Match qualified by strobe so each cycle counts once
  assign lp_hit = link.addr_strobe && !link.read_write
                  && (link.cpu_address_lines == TRIGGER_ADDRESS)
                  && (link.cycle_function_code == FC_SUPER_DATA)
                  && (state_reg == RUN);
  // Byte mode needs one more stage for the immediate
  assign cycle_target = link.byte_mode ? CYCLES_8BIT : CYCLES_16BIT;
  assign last_fetch   = (state_reg == COUNTING) && link.addr_strobe
                        && (cycle_count == cycle_target - CNT_W'(1));
  assign level_seen   = (ipl_reg == wake_level);

  // Stop once the final counted strobe is registered as done; restart only once stable
  assign stop_go       = (state_reg == COUNTING) && count_done;
  assign restart_go    = (state_reg == WAKING) && stable_sync_reg;
  // Count starts again from zero once the processor has stopped
  assign counter_clear = (state_reg == STOPPED);

  // Trigger write is the first counted cycle, then the opcode fetch, then
  // one immediate fetch or two in byte mode; later strobes are ignored
  // because the counter drops out of its active state at the target
  bus_cycle_counter #(
    .W (CNT_W)
  ) i_bus_cycle_counter (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clear    (counter_clear),
    .start    (lp_hit),
    .strobe   (link.addr_strobe),
    .target   (cycle_target),
    .count    (cycle_count),
    .done     (count_done)
  );

  // Sequencer; wake only on the expected level, restart only when stable
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      RUN:      if (lp_hit) state_next = COUNTING;
      COUNTING: if (count_done) state_next = STOPPED;
      STOPPED:  if (level_seen) state_next = WAKING;
      WAKING:   if (stable_sync_reg) state_next = RESUMING;
      RESUMING: state_next = RUN;
    endcase
  end

  // Stable flag is a pin, so it is resynchronised before use; a wake
  // that races the oscillator start is then delayed, never cut short
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      stable_meta_reg <= 1'b0;
      stable_sync_reg <= 1'b0;
    end
    else
    begin
      stable_meta_reg <= clock_stable;
      stable_sync_reg <= stable_meta_reg;
    end
  end

  // Interrupt lines are pins too; levels are held long enough that a
  // skew between bits only delays the match by a cycle
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ipl_meta_reg <= '0;
      ipl_reg      <= '0;
    end
    else
    begin
      ipl_meta_reg <= irq_level;
      ipl_reg      <= ipl_meta_reg;
    end
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      state_reg <= RUN;
    else
      state_reg <= state_next;
  end

  // Enable is a clean registered level; the cell gate must latch it on low clock
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      clk_en_reg <= 1'b1;
    else if (stop_go)
      clk_en_reg <= 1'b0;
    else if (restart_go)
      clk_en_reg <= 1'b1;
  end

  // Bus handover requested on the last fetch, so the grant lands once the
  // status word has been fetched, at the edge that stops the clock; it must fall again before
  // the processor may resume, or it would stay parked off the bus
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      bus_req_reg <= 1'b0;
    else if (last_fetch && tristate_en)
      bus_req_reg <= 1'b1;
    else if (state_reg == RESUMING)
      bus_req_reg <= 1'b0;
  end

  // Stopped status spans the wait for the level and for a stable clock
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      stopped_reg <= 1'b0;
    else
      stopped_reg <= is_parked(state_next);
  end

  // One-cycle pulse as the processor is let go
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      wake_done_reg <= 1'b0;
    else
      wake_done_reg <= (state_reg == RESUMING);
  end

  // Every output comes straight from its register, so the far end never
  // sees a decode glitch on the clock enable or the bus request
  assign link.cpu_clk_en         = clk_en_reg;
  assign link.bus_request_in     = bus_req_reg;
  assign link.interrupt_level_in = ipl_reg;
  assign cpu_stopped             = stopped_reg;
  assign wake_done               = wake_done_reg;
endmodule // lp_clock_ctl

// ===== verilog/lp_clock_cpu.sv
// Processor-side end: trap, trigger write, stop fetches, frozen state
`timescale 1ns/1ps
module lp_clock_cpu
  import lp_clock_pkg::*;
#(
  parameter logic [23:0] TRIGGER_ADDRESS = LP_ADDRESS
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  lp_clock_if.cpu                link,
  input  wire logic              trap_request,
  input  wire logic [DATA_W-1:0] stop_operand,
  input  wire logic              data_width_8,
  output logic                   in_supervisor,
  output logic                   low_power_active,
  output logic                   resumed,
  output logic [DATA_W-1:0]      status_word
);
  import lp_clock_pkg::*;

  typedef enum logic [2:0] {IDLE, TRAP, LP_WRITE, OP_FETCH, IMM_FETCH, HALTED,
                            RETURN} cpu_state_t;

  cpu_state_t        state_reg, state_next;
  logic [DATA_W-1:0] sr_reg, saved_sr_reg;
  logic [1:0]        imm_cnt_reg;
  logic              trap_pend_reg;
  logic              strobe_reg, rw_reg, drive_reg, grant_reg, resumed_reg, width_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [FC_W-1:0]   fc_reg;
  logic              step;
  logic [1:0]        imm_total;
  logic              wake_ok;
  logic              halted_reg;

  // All progress waits on the gated clock, so state freezes when stopped
  assign step      = link.cpu_clk_en;
  assign imm_total = width_reg ? IMM_FETCH_8BIT : IMM_FETCH_16BIT;
  assign wake_ok   = (link.interrupt_level_in > sr_reg[STATUS_MASK_HI:STATUS_MASK_LO])
                     && !link.bus_request_in;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      IDLE:      if (trap_pend_reg) state_next = TRAP;
      TRAP:      state_next = LP_WRITE;
      LP_WRITE:  state_next = OP_FETCH;
      OP_FETCH:  state_next = IMM_FETCH;
      IMM_FETCH: if (imm_cnt_reg == imm_total - 2'h1) state_next = HALTED;
      HALTED:    if (wake_ok) state_next = RETURN;
      RETURN:    state_next = IDLE;                                  // return_from_exception
    endcase
  end

  // Data width is a static strap, sampled on every cycle in the idle state
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      width_reg <= 1'b0;
    else if (state_reg == IDLE)
      width_reg <= data_width_8;
  end

  // Sequencer and status word; a trap enters supervisor mode
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state_reg     <= IDLE;
      sr_reg        <= STATUS_RESET;
      saved_sr_reg  <= STATUS_RESET;
      imm_cnt_reg   <= 2'h0;
      trap_pend_reg <= 1'b0;
      resumed_reg   <= 1'b0;
      halted_reg    <= 1'b0;
    end
    else
    begin
      if (trap_request)
        trap_pend_reg <= 1'b1;
      else if (step && state_reg == IDLE)
        trap_pend_reg <= 1'b0;
      resumed_reg <= step && (state_reg == RETURN);
      if (step)
      begin
        state_reg <= state_next;
        halted_reg <= (state_next == HALTED);
        if (state_reg == TRAP)
        begin
          saved_sr_reg         <= sr_reg;
          sr_reg[STATUS_SUPER] <= 1'b1;
        end
        if (state_reg == IMM_FETCH && state_next == HALTED)
          sr_reg <= stop_operand;
        if (state_reg == RETURN)
          sr_reg <= saved_sr_reg;
        imm_cnt_reg <= (state_reg == IMM_FETCH) ? imm_cnt_reg + 2'h1 : 2'h0;
      end
    end
  end

  // One strobe per bus cycle; pins float while the bus is granted
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      strobe_reg <= 1'b0;
      rw_reg     <= 1'b1;
      addr_reg   <= '0;
      fc_reg     <= FC_USER_DATA;
      drive_reg  <= 1'b1;
      grant_reg  <= 1'b0;
    end
    else
    begin
      grant_reg <= link.bus_request_in && state_reg != LP_WRITE;
      drive_reg <= !(link.bus_request_in && state_reg != LP_WRITE);
      strobe_reg <= step && (state_next == LP_WRITE || state_next == OP_FETCH
                    || (state_next == IMM_FETCH && state_reg != TRAP));
      if (step && state_next == LP_WRITE)
      begin
        rw_reg   <= 1'b0;
        addr_reg <= TRIGGER_ADDRESS;
        fc_reg   <= sr_reg[STATUS_SUPER] || state_reg == TRAP ? FC_SUPER_DATA : FC_USER_DATA;
      end
      else if (step && (state_next == OP_FETCH || state_next == IMM_FETCH))
      begin
        rw_reg <= 1'b1;
        fc_reg <= FC_SUPER_PROG;
      end
    end
  end

  assign link.cpu_address_lines   = addr_reg;
  assign link.cpu_data_lines      = LP_WRITE_DATA;
  assign link.cycle_function_code = fc_reg;
  assign link.read_write          = rw_reg;
  assign link.addr_strobe         = strobe_reg;
  assign link.bus_drive_en        = drive_reg;
  assign link.byte_mode           = width_reg;
  assign link.bus_grant           = grant_reg;
  assign in_supervisor            = sr_reg[STATUS_SUPER];
  assign low_power_active         = halted_reg;
  assign resumed                  = resumed_reg;
  assign status_word              = sr_reg;
endmodule // lp_clock_cpu

// ===== verification/lp_clock_chk.sv
// Concurrent checks on the link between processor and clock-stop logic
`timescale 1ns/1ps
module lp_clock_chk
  import lp_clock_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] cpu_address_lines,
  input wire logic [DATA_W-1:0] cpu_data_lines,
  input wire logic [FC_W-1:0]   cycle_function_code,
  input wire logic              read_write,
  input wire logic              addr_strobe,
  input wire logic              bus_drive_en,
  input wire logic              byte_mode,
  input wire logic              bus_grant,
  input wire logic              bus_request_in,
  input wire logic              cpu_clk_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Supervisor data write to the trigger address
  wire hit = addr_strobe && !read_write && (cpu_address_lines == LP_ADDRESS)
             && (cycle_function_code == FC_SUPER_DATA);

  AST_STOP_WORD: assert property (
    hit && !byte_mode |-> ##1 cpu_clk_en [*2] ##[1:2] !cpu_clk_en)
    else $error("Word mode clock stop at wrong cycle");
  AST_STOP_BYTE: assert property (
    hit && byte_mode |-> ##1 cpu_clk_en [*3] ##[1:2] !cpu_clk_en)
    else $error("Byte mode clock stop at wrong cycle");
  AST_STOP_HOLD: assert property (
    $fell(cpu_clk_en) |-> !cpu_clk_en [*2])
    else $error("Clock restarted too soon");
  AST_NO_RUNT: assert property (
    $rose(cpu_clk_en) |-> cpu_clk_en [*3])
    else $error("Clock enable pulse too short");
  AST_FROZEN: assert property (
    !cpu_clk_en && !$past(cpu_clk_en) |-> !addr_strobe && $stable(cycle_function_code))
    else $error("Bus activity while clock stopped");
  AST_WRITE_SUPER: assert property (
    addr_strobe && !read_write |-> cycle_function_code == FC_SUPER_DATA)
    else $error("Write outside supervisor data space");
  AST_WRITE_DATA: assert property (
    addr_strobe && !read_write |-> cpu_data_lines == LP_WRITE_DATA)
    else $error("Trigger write data wrong");
  AST_GRANT_REQ: assert property (
    bus_grant |-> $past(bus_request_in))
    else $error("Grant without request");
  AST_GRANT_FLOAT: assert property (
    $rose(bus_grant) |-> ##[0:1] !bus_drive_en)
    else $error("Bus still driven after grant");
  AST_REQ_DROP: assert property (
    $rose(cpu_clk_en) |-> ##[0:2] !bus_request_in)
    else $error("Bus request held after restart");
  AST_RESET: assert property (
    $rose(nrst) |-> cpu_clk_en && !bus_request_in && !addr_strobe)
    else $error("Reset state wrong");
endmodule // lp_clock_chk

// ===== verification/lp_clock_tb.sv
// Self-checking bench: both ends joined, sleep and wake sequences
`timescale 1ns/1ps
module cpu_low_power_clock_stop_tb;
  import lp_clock_pkg::*;
  logic              core_clk = 1'b0;
  logic              nrst = 1'b0;
  logic              trap_request = 1'b0;
  logic [DATA_W-1:0] stop_operand = 16'h2000;
  logic              data_width_8 = 1'b0;
  logic [IPL_W-1:0]  irq_level = 3'h0;
  logic [IPL_W-1:0]  wake_level = 3'h7;
  logic              clock_stable = 1'b1;
  logic              tristate_en = 1'b0;
  logic              cpu_stopped, wake_done, in_supervisor;
  logic              low_power_active, resumed;
  logic [DATA_W-1:0] status_word;
  int                miscompares = 0;
  int                check_count = 0;

  lp_clock_if link ();

  lp_clock_ctl i_lp_clock_ctl (
    .core_clk(core_clk), .nrst(nrst), .link(link), .irq_level(irq_level),
    .wake_level(wake_level), .clock_stable(clock_stable), .tristate_en(tristate_en),
    .cpu_stopped(cpu_stopped), .wake_done(wake_done)
  );
  lp_clock_cpu i_lp_clock_cpu (
    .core_clk(core_clk), .nrst(nrst), .link(link), .trap_request(trap_request),
    .stop_operand(stop_operand), .data_width_8(data_width_8),
    .in_supervisor(in_supervisor), .low_power_active(low_power_active),
    .resumed(resumed), .status_word(status_word)
  );
  lp_clock_chk i_lp_clock_chk (
    .core_clk(core_clk), .nrst(nrst), .cpu_address_lines(link.cpu_address_lines),
    .cpu_data_lines(link.cpu_data_lines), .cycle_function_code(link.cycle_function_code),
    .read_write(link.read_write), .addr_strobe(link.addr_strobe),
    .bus_drive_en(link.bus_drive_en), .byte_mode(link.byte_mode),
    .bus_grant(link.bus_grant), .bus_request_in(link.bus_request_in),
    .cpu_clk_en(link.cpu_clk_en)
  );

  // 100 ns period
  always #50 core_clk = ~core_clk;

  // Values are compared four-state so an unknown never matches
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Reset state at both ends
  task automatic t_reset();
    @(negedge core_clk);
    check(link.cpu_clk_en, 1'b1);
    check(link.bus_request_in, 1'b0);
    check(status_word, STATUS_RESET);
    check(low_power_active, 1'b0);
    $display("test reset done");
  endtask

  // Trap, trigger write, stop; hold with clock unstable, then wake
  task automatic t_sleep(input logic w8, input logic tri_on, input logic [15:0] op);
    logic wd;
    logic rs;
    @(posedge core_clk);
    data_width_8 <= w8;
    tristate_en <= tri_on;
    stop_operand <= op;
    irq_level <= 3'h0;
    wake_level <= op[10:8] + 3'h1;
    clock_stable <= 1'b0;
    repeat (2) @(posedge core_clk);
    trap_request <= 1'b1;
    @(posedge core_clk);
    trap_request <= 1'b0;
    for (int i = 0; i < 40 && cpu_stopped !== 1'b1; i++) @(negedge core_clk);
    check(in_supervisor, 1'b1);
    check(link.byte_mode, w8);
    check(cpu_stopped, 1'b1);
    check(link.cpu_clk_en, 1'b0);
    check(low_power_active, 1'b1);
    check(status_word, op);
    check(link.bus_request_in, tri_on);
    // Wake level present but clock not yet stable: must stay stopped
    @(posedge core_clk);
    irq_level <= op[10:8] + 3'h1;
    repeat (12) @(negedge core_clk);
    check(link.cpu_clk_en, 1'b0);
    check(link.interrupt_level_in, op[10:8] + 3'h1);
    @(posedge core_clk);
    clock_stable <= 1'b1;
    wd = 1'b0;
    rs = 1'b0;
    for (int i = 0; i < 40 && !(wd && rs); i++)
    begin
      @(negedge core_clk);
      wd |= (wake_done === 1'b1);
      rs |= (resumed === 1'b1);
    end
    check(wd, 1'b1);
    check(rs, 1'b1);
    check(link.cpu_clk_en, 1'b1);
    check(link.bus_request_in, 1'b0);
    check(low_power_active, 1'b0);
    check(cpu_stopped, 1'b0);
    check(status_word, STATUS_RESET);
    @(posedge core_clk);
    irq_level <= 3'h0;
    repeat (4) @(posedge core_clk);
    $display("test sleep width8=%0d tristate=%0d done", w8, tri_on);
  endtask

  // Reset while stopped with the bus handed over: both ends run again
  task automatic t_reset_mid();
    @(posedge core_clk);
    tristate_en <= 1'b1;
    trap_request <= 1'b1;
    @(posedge core_clk);
    trap_request <= 1'b0;
    for (int i = 0; i < 40 && cpu_stopped !== 1'b1; i++) @(negedge core_clk);
    check(link.bus_request_in, 1'b1);
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    check(link.cpu_clk_en, 1'b1);
    check(link.bus_request_in, 1'b0);
    check(cpu_stopped, 1'b0);
    check(status_word, STATUS_RESET);
    $display("test reset mid-run done");
  endtask

  // Watchdog: well under two hundred cycles expected
  initial
  begin
    repeat (3000) @(posedge core_clk);
    miscompares++;
    close_out();
  end

  initial
  begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_sleep(1'b0, 1'b0, 16'h2300);
    t_sleep(1'b1, 1'b1, 16'h2500);
    t_reset_mid();
    t_sleep(1'b0, 1'b1, 16'h2000);
    close_out();
  end
endmodule // cpu_low_power_clock_stop_tb
